// >>> rtl/chgadc_defines.svh
// Offsets, field positions, reset values and limits of the ADC result bank
// How it works
// - Battery current result at 0x33, signed 16 bits, 1 mA step, clears to zero.
// - Battery current sign bit is 1 while discharging, 0 while charging unless averaged with a stored discharge.
// - Forward charging reports current into the battery as a positive value.
// - OTG and battery-only modes report discharge only when sense enable is set.
// - Bus voltage result at 0x35, unsigned, 1 mV step, clears to zero.
// - First adapter voltage result at 0x37, unsigned, 1 mV step, clears to zero.
// - Second adapter voltage result at 0x39, unsigned, 1 mV step, clears to zero.
// - Remote-sense battery voltage result at 0x3B, unsigned, clears to zero.
// - System voltage result at 0x3D, unsigned, 1 mV step, clears to zero.
// - Thermistor result at 0x3F, clears to zero.
// - Disable bits at 0x2F drop battery current, bus, battery, system, thermistor.
// - Disable bits at 0x30 drop first and second adapter voltage channels.
// - Running average never applies to battery current while discharging.
`ifndef CHGADC_DEFINES_SVH
`define CHGADC_DEFINES_SVH

`define CHGADC_OFS_DIS0       8'h2F
`define CHGADC_OFS_DIS1       8'h30
`define CHGADC_OFS_IBAT       8'h33
`define CHGADC_OFS_VBUS       8'h35
`define CHGADC_OFS_VAC1       8'h37
`define CHGADC_OFS_VAC2       8'h39
`define CHGADC_OFS_VSNS       8'h3B
`define CHGADC_OFS_VSYS       8'h3D
`define CHGADC_OFS_THERM      8'h3F

`define CHGADC_DIS0_WMASK     8'hFE
`define CHGADC_DIS1_WMASK     8'hF0
`define CHGADC_DIS_RESET      8'h00
`define CHGADC_RESULT_RESET   16'h0000

`define CHGADC_BIT_IBAT_OFF   6
`define CHGADC_BIT_VBUS_OFF   5
`define CHGADC_BIT_VBAT_OFF   4
`define CHGADC_BIT_VSYS_OFF   3
`define CHGADC_BIT_THERM_OFF  2
`define CHGADC_BIT_VAC2_OFF   5
`define CHGADC_BIT_VAC1_OFF   4

`define CHGADC_READ_LATENCY   1

`endif

// >>> rtl/chgadc_pkg.sv
// Types shared by the ADC result bank
package chgadc_pkg;

   typedef enum logic [2:0] {
      CH_IBAT  = 3'h0,
      CH_VBUS  = 3'h1,
      CH_VAC1  = 3'h2,
      CH_VAC2  = 3'h3,
      CH_VSNS  = 3'h4,
      CH_VSYS  = 3'h5,
      CH_THERM = 3'h6
   } chgadc_chan_t;

   typedef enum logic [1:0] {
      MODE_FORWARD = 2'h0,
      MODE_OTG     = 2'h1,
      MODE_BAT_HIZ = 2'h2
   } chgadc_mode_t;

   // One finished conversion; value is a magnitude
   typedef struct packed {
      chgadc_chan_t chan;
      logic [15:0]  value;
      logic         discharging;
   } chgadc_conv_t;

endpackage : chgadc_pkg

// >>> rtl/chgadc_result_calc.sv
// Next result word: plain sample or running average with the old word
`timescale 1ns/100ps
module chgadc_result_calc #(
   parameter int W = 16
) (
   // Operands
   input  wire logic [W-1:0] old_value,
   input  wire logic [W-1:0] new_value,
   input  wire logic         is_signed,
   input  wire logic         average,
   // Result
   output logic      [W-1:0] next_value
);

   function automatic logic [W-1:0] avg2(input logic [W-1:0] a,
                                         input logic [W-1:0] b,
                                         input logic         sgn);
      logic [W:0] sum;
      sum = {sgn & a[W-1], a} + {sgn & b[W-1], b};
      return sum[W:1];
   endfunction : avg2

   assign next_value = average ? avg2(old_value, new_value, is_signed) : new_value;

endmodule : chgadc_result_calc

// >>> rtl/chgadc_result_bank.sv
// ADC result register bank with channel disable registers
`timescale 1ns/100ps
`include "chgadc_defines.svh"
module chgadc_result_bank (
   // Clock and reset
   input  wire logic                      clock,
   input  wire logic                      rst,
   // Finished conversions from the ADC core
   input  wire logic                      conv_valid,
   input  wire chgadc_pkg::chgadc_conv_t  conv,
   // Charger state
   input  wire chgadc_pkg::chgadc_mode_t  charge_mode,
   input  wire logic                      battery_discharge_sense_enable,
   input  wire logic                      running_average_select,
   // Register access port
   input  wire logic [7:0]                reg_addr,
   input  wire logic                      reg_wr,
   input  wire logic [7:0]                reg_wdata,
   input  wire logic                      reg_rd,
   output logic      [15:0]               reg_rdata,
   output logic                           reg_rvalid,
   // Channel enables seen by the ADC sequencer
   output logic      [6:0]                chan_enable
);

   logic [6:0][15:0] result_r;
   logic [7:0]       dis0_r;
   logic [7:0]       dis1_r;
   logic [15:0]      rdata_r;
   logic             rvalid_r;

   ////////////////////////////////////////////////////////////////////////////
   // Channel gating

   function automatic logic [6:0] off_vector(input logic [7:0] d0, input logic [7:0] d1);
      logic [6:0] v;
      v = 7'h00;
      v[chgadc_pkg::CH_IBAT]  = d0[`CHGADC_BIT_IBAT_OFF];
      v[chgadc_pkg::CH_VBUS]  = d0[`CHGADC_BIT_VBUS_OFF];
      v[chgadc_pkg::CH_VSNS]  = d0[`CHGADC_BIT_VBAT_OFF];
      v[chgadc_pkg::CH_VSYS]  = d0[`CHGADC_BIT_VSYS_OFF];
      v[chgadc_pkg::CH_THERM] = d0[`CHGADC_BIT_THERM_OFF];
      v[chgadc_pkg::CH_VAC1]  = d1[`CHGADC_BIT_VAC1_OFF];
      v[chgadc_pkg::CH_VAC2]  = d1[`CHGADC_BIT_VAC2_OFF];
      return v;
   endfunction : off_vector

   wire logic [6:0] chan_off = off_vector(dis0_r, dis1_r);
   wire logic       is_ibat  = (conv.chan == chgadc_pkg::CH_IBAT);
   wire logic       chan_ok  = (conv.chan != 3'h7) && !chan_off[conv.chan];
   wire logic       store    = conv_valid && chan_ok;
   assign chan_enable = ~chan_off;

   ////////////////////////////////////////////////////////////////////////////
   // Battery current sign and mode gating

   // Discharge outside forward mode is only visible with sense enabled
   wire logic quiet_mode  = (charge_mode == chgadc_pkg::MODE_OTG) ||
                            (charge_mode == chgadc_pkg::MODE_BAT_HIZ);
   wire logic disch_block = quiet_mode && !battery_discharge_sense_enable;
   wire logic [15:0] ibat_signed = conv.discharging ? (~conv.value + 16'h0001)
                                                    : conv.value;
   wire logic [15:0] ibat_word   = (conv.discharging && disch_block) ? 16'h0000
                                                                      : ibat_signed;
   wire logic [15:0] sample_word = is_ibat ? ibat_word : conv.value;
   // Averaging a sign flip would smear across zero, so discharge stays raw
   wire logic use_avg = running_average_select && !(is_ibat && conv.discharging);

   logic [15:0] next_word;

   chgadc_result_calc #(
      .W (16)
   ) u_calc (
      .old_value  (result_r[conv.chan]),
      .new_value  (sample_word),
      .is_signed  (is_ibat),
      .average    (use_avg),
      .next_value (next_word)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Result storage

   // Whole word written in one edge, so a read never sees half an update
   always_ff @(posedge clock) begin
      if (rst) begin
         result_r <= {7{`CHGADC_RESULT_RESET}};
      end else if (store) begin
         result_r[conv.chan] <= next_word;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         dis0_r <= `CHGADC_DIS_RESET;
         dis1_r <= `CHGADC_DIS_RESET;
      end else if (reg_wr) begin
         if (reg_addr == `CHGADC_OFS_DIS0) begin
            dis0_r <= reg_wdata & `CHGADC_DIS0_WMASK;
         end
         if (reg_addr == `CHGADC_OFS_DIS1) begin
            dis1_r <= reg_wdata & `CHGADC_DIS1_WMASK;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read decode

   function automatic logic [15:0] read_mux(input logic [7:0]       a,
                                            input logic [6:0][15:0] r,
                                            input logic [7:0]       d0,
                                            input logic [7:0]       d1);
      logic [15:0] q;
      q = 16'h0000;
      unique case (a)
         `CHGADC_OFS_DIS0:  q = {8'h00, d0};
         `CHGADC_OFS_DIS1:  q = {8'h00, d1};
         `CHGADC_OFS_IBAT:  q = r[chgadc_pkg::CH_IBAT];
         `CHGADC_OFS_VBUS:  q = r[chgadc_pkg::CH_VBUS];
         `CHGADC_OFS_VAC1:  q = r[chgadc_pkg::CH_VAC1];
         `CHGADC_OFS_VAC2:  q = r[chgadc_pkg::CH_VAC2];
         `CHGADC_OFS_VSNS:  q = r[chgadc_pkg::CH_VSNS];
         `CHGADC_OFS_VSYS:  q = r[chgadc_pkg::CH_VSYS];
         `CHGADC_OFS_THERM: q = r[chgadc_pkg::CH_THERM];
         default:           q = 16'h0000;
      endcase
      return q;
   endfunction : read_mux

   wire logic [15:0] read_word = read_mux(reg_addr, result_r, dis0_r, dis1_r);

   always_ff @(posedge clock) begin
      if (rst) begin
         rdata_r  <= 16'h0000;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= reg_rd;
         if (reg_rd) begin
            rdata_r <= read_word;
         end
      end
   end

   assign reg_rdata  = rdata_r;
   assign reg_rvalid = rvalid_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   wire logic [6:0] off_now = chan_off;

   sequence s_ibat_conv;
      conv_valid && is_ibat && !off_now[chgadc_pkg::CH_IBAT];
   endsequence

   sequence s_ibat_disch_visible;
      s_ibat_conv ##0 conv.discharging && !disch_block && (conv.value != 16'h0000)
         && !conv.value[15];
   endsequence

   a_reset_clears_all: assert property (@(posedge clock)
      rst |=> (result_r == {7{16'h0000}}) && (dis0_r == 8'h00) && (dis1_r == 8'h00))
      else $error("results or disable bits not cleared by reset");

   a_ibat_charge_pos: assert property (@(posedge clock) disable iff (rst)
      s_ibat_conv ##0 (!conv.discharging && !running_average_select)
      |=> result_r[chgadc_pkg::CH_IBAT] == $past(conv.value))
      else $error("charging current not stored as positive value");

   a_ibat_disch_sign: assert property (@(posedge clock) disable iff (rst)
      s_ibat_disch_visible |=> result_r[chgadc_pkg::CH_IBAT][15] == 1'b1)
      else $error("discharge current lacks sign bit");

   a_ibat_mode_gate: assert property (@(posedge clock) disable iff (rst)
      s_ibat_conv ##0 (conv.discharging && quiet_mode && !battery_discharge_sense_enable)
      |=> result_r[chgadc_pkg::CH_IBAT] == 16'h0000)
      else $error("discharge reported while sense enable is clear");

   a_no_avg_disch: assert property (@(posedge clock) disable iff (rst)
      s_ibat_disch_visible ##0 running_average_select
      |=> result_r[chgadc_pkg::CH_IBAT] == 16'(~$past(conv.value) + 16'h0001))
      else $error("discharge current was averaged");

   a_chan_off_hold: assert property (@(posedge clock) disable iff (rst)
      (conv_valid && dis0_r[`CHGADC_BIT_VBUS_OFF] && conv.chan == chgadc_pkg::CH_VBUS)
      |=> $stable(result_r[chgadc_pkg::CH_VBUS]))
      else $error("disabled bus voltage channel updated");

   a_vac_off_hold: assert property (@(posedge clock) disable iff (rst)
      (conv_valid && dis1_r[`CHGADC_BIT_VAC2_OFF] && conv.chan == chgadc_pkg::CH_VAC2)
      |=> $stable(result_r[chgadc_pkg::CH_VAC2]))
      else $error("disabled adapter channel updated");

   a_result_hold: assert property (@(posedge clock) disable iff (rst)
      !conv_valid |=> $stable(result_r))
      else $error("result changed without a conversion");

   a_read_vbus: assert property (@(posedge clock) disable iff (rst)
      (reg_rd && reg_addr == `CHGADC_OFS_VBUS)
      |=> reg_rvalid && reg_rdata == $past(result_r[chgadc_pkg::CH_VBUS]))
      else $error("bus voltage read returned wrong word");

   a_read_therm: assert property (@(posedge clock) disable iff (rst)
      (reg_rd && reg_addr == `CHGADC_OFS_THERM)
      |=> reg_rdata == $past(result_r[chgadc_pkg::CH_THERM]))
      else $error("thermistor read returned wrong word");

   a_ibat_charge_sign: assert property (@(posedge clock) disable iff (rst)
      s_ibat_conv ##0 (!conv.discharging && !running_average_select && !conv.value[15])
      |=> result_r[chgadc_pkg::CH_IBAT][15] == 1'b0)
      else $error("charging current carries the sign bit");

   a_read_ibat: assert property (@(posedge clock) disable iff (rst)
      (reg_rd && reg_addr == `CHGADC_OFS_IBAT)
      |=> reg_rvalid && reg_rdata == $past(result_r[chgadc_pkg::CH_IBAT]))
      else $error("battery current read returned wrong word");

   a_dis0_write: assert property (@(posedge clock) disable iff (rst)
      (reg_wr && reg_addr == `CHGADC_OFS_DIS0)
      |=> (chan_enable[chgadc_pkg::CH_IBAT] == !$past(reg_wdata[6]))
         && (chan_enable[chgadc_pkg::CH_THERM] == !$past(reg_wdata[2]))
         && !dis0_r[0])
      else $error("disable register 0 write did not steer channels");

   a_dis1_write: assert property (@(posedge clock) disable iff (rst)
      (reg_wr && reg_addr == `CHGADC_OFS_DIS1)
      |=> (chan_enable[chgadc_pkg::CH_VAC1] == !$past(reg_wdata[4]))
         && (chan_enable[chgadc_pkg::CH_VAC2] == !$past(reg_wdata[5]))
         && (dis1_r[3:0] == 4'h0))
      else $error("disable register 1 write did not steer channels");

endmodule : chgadc_result_bank

// >>> dv/chgadc_host_model.sv
// Host side of the register port: issues single reads and writes
`timescale 1ns/100ps
module chgadc_host_model (
   // Clock
   input  wire logic        clock,
   // Register port
   output logic      [7:0]  reg_addr,
   output logic             reg_wr,
   output logic      [7:0]  reg_wdata,
   output logic             reg_rd,
   input  wire logic [15:0] reg_rdata,
   input  wire logic        reg_rvalid
);
   initial {reg_addr, reg_wr, reg_wdata, reg_rd} = 18'h00000;
   // Idle lines show the inverse so stale values cannot pass
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      {reg_addr, reg_wr, reg_wdata} <= {a, 1'b1, d};
      @(posedge clock);
      {reg_addr, reg_wr, reg_wdata} <= {~a, 1'b0, ~d};
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
      @(posedge clock);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clock);
      {reg_addr, reg_rd} <= {~a, 1'b0};
      @(posedge clock);
      ok = reg_rvalid;
      d = reg_rdata;
   endtask : rd
endmodule : chgadc_host_model

// >>> dv/chgadc_result_bank_tb.sv
// Self-checking bench for the ADC result bank
`timescale 1ns/100ps
module chgadc_result_bank_tb;
   logic                     clock = 1'b0;
   logic                     rst = 1'b1;
   logic                     conv_valid = 1'b0;
   chgadc_pkg::chgadc_conv_t conv = '0;
   chgadc_pkg::chgadc_mode_t charge_mode = chgadc_pkg::MODE_FORWARD;
   logic                     sen = 1'b0;
   logic                     avg = 1'b0;
   logic [7:0]               reg_addr, reg_wdata, dis0, dis1;
   logic                     reg_wr, reg_rd, reg_rvalid;
   logic [15:0]              reg_rdata;
   logic [6:0]               chan_enable;
   logic [15:0]              exp_r [7];
   int                       seed = 63240;
   int                       mismatches = 0;
   int                       compares = 0;
   always #4 clock = ~clock;
   chgadc_result_bank u_chgadc_result_bank (.clock(clock), .rst(rst),
      .conv_valid(conv_valid), .conv(conv), .charge_mode(charge_mode),
      .battery_discharge_sense_enable(sen), .running_average_select(avg),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .chan_enable(chan_enable));
   chgadc_host_model u_chgadc_host_model (.clock(clock), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : tally_and_finish
   function automatic logic [6:0] en_exp(input logic [7:0] d0, input logic [7:0] d1);
      return ~{d0[2], d0[3], d0[4], d1[5], d1[4], d0[5], d0[6]};
   endfunction : en_exp
   // Expected word after an accepted conversion
   function automatic logic [15:0] nx(input int ch, input logic [15:0] old, v,
      input logic dn, input chgadc_pkg::chgadc_mode_t m, input logic se, av);
      logic [16:0] s;
      if (ch == 0 && dn) return (m != chgadc_pkg::MODE_FORWARD && !se) ? 16'h0000 : -v;
      if (!av) return v;
      s = (ch == 0) ? {old[15], old} + {1'b0, v} : {1'b0, old} + {1'b0, v};
      return s[16:1];
   endfunction : nx
   task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
      logic [15:0] d;
      logic        ok;
      u_chgadc_host_model.rd(a, d, ok);
      check({15'h0000, ok}, 16'h0001);
      check(d, e);
   endtask : rdchk
   task automatic setdis(input logic [7:0] d0, input logic [7:0] d1);
      u_chgadc_host_model.wr(8'h2F, d0);
      u_chgadc_host_model.wr(8'h30, d1);
      dis0 = d0 & 8'hFE;
      dis1 = d1 & 8'hF0;
      rdchk(8'h2F, {8'h00, dis0});
      rdchk(8'h30, {8'h00, dis1});
      check({9'h000, chan_enable}, {9'h000, en_exp(dis0, dis1)});
   endtask : setdis
   // Sends one conversion, then reads its register back
   task automatic send(input int ch, input logic [15:0] v, input logic dn);
      logic [6:0] ena;
      ena = en_exp(dis0, dis1);
      @(posedge clock);
      conv_valid <= 1'b1;
      conv <= '{chgadc_pkg::chgadc_chan_t'(ch), v, dn};
      @(posedge clock);
      conv_valid <= 1'b0;
      conv <= '{chgadc_pkg::CH_THERM, ~v, ~dn};
      if (ena[ch]) exp_r[ch] = nx(ch, exp_r[ch], v, dn, charge_mode, sen, avg);
      rdchk(8'(8'h33 + 2 * ch), exp_r[ch]);
   endtask : send
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #100000;
      mismatches++;
      tally_and_finish();
   end
   initial begin
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      {dis0, dis1} = 16'h0000;
      foreach (exp_r[c]) exp_r[c] = 16'h0000;
      foreach (exp_r[c]) rdchk(8'(8'h33 + 2 * c), 16'h0000);
      rdchk(8'h34, 16'h0000);
      check({9'h000, chan_enable}, 16'h007F);
      u_chgadc_host_model.wr(8'h33, 8'hA5);
      rdchk(8'h33, 16'h0000);
      $display("test reset and access done");
      for (int i = 0; i < 60; i++) begin
         if (i % 10 == 9) setdis(8'($random(seed)), 8'($random(seed)));
         charge_mode <= chgadc_pkg::chgadc_mode_t'($unsigned($random(seed)) % 3);
         sen <= 1'($random(seed));
         avg <= 1'($random(seed));
         send($unsigned($random(seed)) % 7, 16'($unsigned($random(seed)) % 8001),
            1'($random(seed)));
      end
      $display("test random conversions done");
      setdis(8'h00, 8'h00);
      charge_mode <= chgadc_pkg::MODE_OTG;
      sen <= 1'b0;
      avg <= 1'b0;
      send(0, 16'h0064, 1'b1);
      sen <= 1'b1;
      send(0, 16'h0064, 1'b1);
      charge_mode <= chgadc_pkg::MODE_BAT_HIZ;
      sen <= 1'b0;
      send(0, 16'h0064, 1'b1);
      sen <= 1'b1;
      avg <= 1'b1;
      send(0, 16'h00C8, 1'b1);
      charge_mode <= chgadc_pkg::MODE_FORWARD;
      avg <= 1'b0;
      send(0, 16'h012C, 1'b0);
      $display("test battery current sign done");
      setdis(8'hFF, 8'hFF);
      foreach (exp_r[c]) send(c, 16'h1234, 1'b0);
      $display("test disabled channels done");
      // Reset again with results and disable bits set
      @(posedge clock);
      rst <= 1'b1;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      {dis0, dis1} = 16'h0000;
      foreach (exp_r[c]) exp_r[c] = 16'h0000;
      foreach (exp_r[c]) rdchk(8'(8'h33 + 2 * c), 16'h0000);
      rdchk(8'h2F, 16'h0000);
      rdchk(8'h30, 16'h0000);
      check({9'h000, chan_enable}, 16'h007F);
      $display("test reset in mid-run done");
      tally_and_finish();
   end
endmodule : chgadc_result_bank_tb
